// *** logic/bfd_decoder.sv ***
// Purpose: instruction field decoder with branch target and count logic
// Assumes: software picks the form; writing the instruction word decodes it
// Notes: apb slave with no wait states, read data registered in setup
`timescale 1ns/1ps
module bfd_decoder
  import bfd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic DECODE_VALID,
  output logic BRANCH_TAKEN,
  output logic [63:0] BRANCH_TARGET,
  output logic INVALID_FORM,
  output logic LINK_WRITE
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] insn;
  logic [63:0] pc;
  logic [63:0] count_reg;
  logic [63:0] link_reg;
  logic [31:0] condition_reg;
  logic [31:0] xo_expect;
  logic go;
  logic [31:0] status;
  logic [31:0] ops;
  logic [31:0] opc;
  logic [31:0] sel;
  logic [31:0] masks;
  logic [31:0] bitmask;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr = PSEL & PENABLE & PWRITE;
  wire [7:0] a = PADDR;
  wire hit = (a[1:0] == 2'h0) && (a <= OFS_BITMASK);

  function automatic logic wr_to(input logic [7:0] ofs, input logic [7:0] at,
                                 input logic w);
    wr_to = w && (at == ofs);
  endfunction : wr_to

  // --------------------------------------------------------------
  // field extraction
  // --------------------------------------------------------------
  bfd_form_type form;
  assign form = bfd_form_type'(ctrl[CTRL_FORM_LSB +: 4]);
  wire mode64 = ctrl[CTRL_MODE64];
  wire [5:0] primary_opcode = insn[F_PRIMARY_OPCODE +: 6];
  wire [4:0] fld6 = insn[F_6 +: 5];
  wire [4:0] fld11 = insn[F_11 +: 5];
  wire [4:0] fld16 = insn[F_16 +: 5];
  wire [4:0] fld21 = insn[F_21 +: 5];
  wire [4:0] fld26 = insn[F_26 +: 5];
  wire record_bit = insn[F_RC];
  wire oe_bit = insn[F_OE];
  wire absolute_addr_bit = insn[F_AA];
  wire link_bit = insn[F_LK];
  wire [4:0] branch_options = fld6;
  wire [4:0] branch_cond_bit_index = fld11;
  wire [4:0] cond_bit_src_b = fld16;
  wire [4:0] result_bit_target = fld6;
  wire [2:0] target_field_select = fld6[4:2];
  wire [2:0] source_field_select = fld11[4:2];
  wire [7:0] cond_field_mask = insn[F_11 + 3 -: 8];
  wire [7:0] fp_status_field_mask = insn[F_BIT6 - 1 -: 8];
  // lowercase spr: halves left to right; uppercase option swaps them
  wire [9:0] spr_lower = {fld11, fld16};
  wire [9:0] spr_upper = {fld16, fld11};
  wire [9:0] spr_num = ctrl[CTRL_SPR_SWAP] ? spr_upper : spr_lower;

  // extended opcode width follows the form
  logic [9:0] extended_opcode;
  always_comb begin
    case (form)
      FORM_X, FORM_XL, FORM_XFX, FORM_XFL: extended_opcode = insn[F_26 +: 10];
      FORM_XO: extended_opcode = {1'b0, insn[F_26 +: 9]};
      FORM_A: extended_opcode = {5'h00, fld26};
      FORM_SC: extended_opcode = {9'h000, insn[F_AA]};
      default: extended_opcode = 10'h000;
    endcase
  end

  // --------------------------------------------------------------
  // form validity
  // --------------------------------------------------------------
  logic resv_bad;
  always_comb begin
    case (form)
      FORM_XFL: resv_bad = insn[F_BIT6] | insn[F_BIT15];
      FORM_XFX: resv_bad = ctrl[CTRL_FXM_VAR] & (insn[F_11 + 4] | insn[F_BIT20]);
      FORM_SC: resv_bad = |insn[F_PRIMARY_OPCODE - 1 : F_AA + 1];
      default: resv_bad = 1'b0;
    endcase
  end
  wire xo_bad = ctrl[CTRL_XO_CHECK] && (extended_opcode != xo_expect[9:0]);
  wire invalid = resv_bad | xo_bad;

  // --------------------------------------------------------------
  // branch target
  // --------------------------------------------------------------
  wire [23:0] long_branch_imm = insn[F_AA + 1 +: 24];
  wire [13:0] cond_branch_disp = insn[F_AA + 1 +: 14];
  wire [15:0] disp16 = insn[15:0];
  wire [63:0] li_ext = {{38{long_branch_imm[23]}}, long_branch_imm, 2'b00};
  wire [63:0] bd_ext = {{48{cond_branch_disp[13]}}, cond_branch_disp, 2'b00};
  wire [63:0] d_ext = {{48{disp16[15]}}, disp16};
  wire [63:0] pc_word = {pc[63:2], 2'b00};
  wire [63:0] disp = (form == FORM_I) ? li_ext : bd_ext;
  wire [63:0] rel_sum = disp + pc_word;
  wire [63:0] raw_tgt = absolute_addr_bit ? disp : rel_sum;
  // the 32-bit variant wraps inside the low word, upper word zero
  wire [63:0] tgt = mode64 ? raw_tgt : {32'h00000000, raw_tgt[31:0]};
  wire [63:0] d_out = mode64 ? d_ext : {32'h00000000, d_ext[31:0]};
  wire [63:0] next_pc = pc_word + INSN_BYTES;

  // --------------------------------------------------------------
  // branch options
  // --------------------------------------------------------------
  wire cond_bit = condition_reg[5'd31 - branch_cond_bit_index];
  wire src_bit_a = condition_reg[5'd31 - fld11];
  wire src_bit_b = condition_reg[5'd31 - cond_bit_src_b];
  wire [63:0] ctr_dec = count_reg - 64'h0000000000000001;
  wire dec_zero_full = mode64 ? (ctr_dec == 64'h0) : (ctr_dec[31:0] == 32'h0);
  wire dec_zero_low = (ctr_dec[31:0] == 32'h0);
  logic bo_dec;
  logic bo_take;
  always_comb begin
    bo_dec = 1'b0;
    bo_take = 1'b0;
    if (!branch_options[4]) begin
      if (branch_options[2]) begin
        bo_take = (cond_bit == branch_options[3]);
      end else begin
        bo_dec = 1'b1;
        bo_take = (cond_bit == branch_options[3]) &&
                  (branch_options[1] ? dec_zero_full : !dec_zero_full);
      end
    end else begin
      if (branch_options[2]) begin
        bo_take = 1'b1;
      end else begin
        bo_dec = 1'b1;
        bo_take = branch_options[1] ? dec_zero_low : !dec_zero_full;
      end
    end
  end
  wire is_b = (form == FORM_B);
  wire is_i = (form == FORM_I);
  wire do_dec = is_b && bo_dec && !invalid;
  wire take = !invalid && (is_i || (is_b && bo_take));
  wire link_wr = !invalid && link_bit && (is_i || is_b || form == FORM_SC);

  // field masks: field i spans doc bits i*4..i*4+3
  wire [31:0] tf_mask = 32'hF0000000 >> {target_field_select, 2'b00};
  wire [31:0] sf_mask = 32'hF0000000 >> {source_field_select, 2'b00};
  wire [3:0] src_field_val = condition_reg[5'd31 - {source_field_select, 2'b00} -: 4];
  wire [31:0] res_bit_mask = 32'h80000000 >> result_bit_target;

  // operand words per form
  logic [31:0] next_ops;
  always_comb begin
    case (form)
      FORM_XFL: next_ops = {fp_status_field_mask, 19'h00000, fld16};
      FORM_XFX: next_ops = {fld6, spr_num, cond_field_mask, 8'h00, record_bit};
      FORM_B: next_ops = {branch_options, branch_cond_bit_index, 22'h000000};
      default: next_ops = {fld6, fld11, fld16, fld21, fld26, 6'h00, record_bit};
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= CTRL_RESET;
      insn <= 32'h00000000;
      pc <= REG64_RESET;
      xo_expect <= 32'h00000000;
      condition_reg <= CR_RESET;
      go <= 1'b0;
    end else begin
      go <= wr_to(OFS_INSN, a, wr);
      if (wr_to(OFS_CTRL, a, wr)) ctrl <= PWDATA;
      if (wr_to(OFS_INSN, a, wr)) insn <= PWDATA;
      if (wr_to(OFS_PC_LO, a, wr)) pc[31:0] <= PWDATA;
      if (wr_to(OFS_PC_HI, a, wr)) pc[63:32] <= PWDATA;
      if (wr_to(OFS_XO_EXP, a, wr)) xo_expect <= PWDATA;
      if (wr_to(OFS_CR, a, wr)) condition_reg <= PWDATA;
    end
  end

  // count and link: software writes and decode never meet in one cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      count_reg <= REG64_RESET;
      link_reg <= REG64_RESET;
    end else begin
      if (go && do_dec) count_reg <= ctr_dec;
      else if (wr_to(OFS_CTR_LO, a, wr)) count_reg[31:0] <= PWDATA;
      else if (wr_to(OFS_CTR_HI, a, wr)) count_reg[63:32] <= PWDATA;
      if (go && link_wr) link_reg <= next_pc;
      else if (wr_to(OFS_LR_LO, a, wr)) link_reg[31:0] <= PWDATA;
      else if (wr_to(OFS_LR_HI, a, wr)) link_reg[63:32] <= PWDATA;
    end
  end

  // decode results, captured one cycle after the instruction write
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DECODE_VALID <= 1'b0;
      BRANCH_TAKEN <= 1'b0;
      BRANCH_TARGET <= REG64_RESET;
      INVALID_FORM <= 1'b0;
      LINK_WRITE <= 1'b0;
      status <= 32'h00000000;
      ops <= 32'h00000000;
      opc <= 32'h00000000;
      sel <= 32'h00000000;
      masks <= 32'h00000000;
      bitmask <= 32'h00000000;
    end else begin
      DECODE_VALID <= go;
      LINK_WRITE <= go && link_wr;
      if (go) begin
        BRANCH_TAKEN <= take;
        BRANCH_TARGET <= (is_i || is_b) ? tgt : d_out;
        INVALID_FORM <= invalid;
        status <= {24'h000000, src_field_val, src_bit_b, src_bit_a, do_dec, take} ^
                  {22'h000000, link_wr, invalid, 8'h00};
        ops <= next_ops;
        opc <= {primary_opcode, extended_opcode, oe_bit, record_bit, 14'h0000};
        sel <= {1'b0, target_field_select, source_field_select, branch_cond_bit_index,
                cond_bit_src_b, result_bit_target, fld11, spr_num[3:0], cond_bit};
        masks <= tf_mask | sf_mask;
        bitmask <= res_bit_mask;
      end else begin
        BRANCH_TAKEN <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // read mux, registered in the setup cycle
  // --------------------------------------------------------------
  logic [31:0] rd;
  always_comb begin
    case (a)
      OFS_CTRL: rd = ctrl;
      OFS_INSN: rd = insn;
      OFS_PC_LO: rd = pc[31:0];
      OFS_PC_HI: rd = pc[63:32];
      OFS_CTR_LO: rd = count_reg[31:0];
      OFS_CTR_HI: rd = count_reg[63:32];
      OFS_LR_LO: rd = link_reg[31:0];
      OFS_LR_HI: rd = link_reg[63:32];
      OFS_CR: rd = condition_reg;
      OFS_TGT_LO: rd = BRANCH_TARGET[31:0];
      OFS_TGT_HI: rd = BRANCH_TARGET[63:32];
      OFS_STATUS: rd = status;
      OFS_OPS: rd = ops;
      OFS_OPC: rd = opc;
      OFS_SEL: rd = sel;
      OFS_XO_EXP: rd = xo_expect;
      OFS_MASKS: rd = masks;
      OFS_BITMASK: rd = bitmask;
      default: rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (setup) begin
      PRDATA <= rd;
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;

endmodule : bfd_decoder

// *** logic/bfd_pkg.sv ***
// Purpose: constants and types of the branch field decoder
// Assumes: instruction bit 0 is the msb; doc bit n sits at insn[31-n]
// Notes: byte offsets on apb, one 32-bit word per register
// What this block does
// - mtspr-style form: bits 11-20 register number or field mask; 21-30 xo; 31 record
// - xo form: target 6-10, sources 11-15/16-20, oe 21, 9-bit xo, record 31
// - nonzero reserved bits or wrong fixed-value field flag invalid form
// - lowercase split fields concatenate left to right; uppercase use own order
// - aa clear: target is sign-extended displacement plus branch address
// - aa set: target is sign-extended displacement alone; 64 or 32 bit extension
// - bits 16-29 are 14-bit signed, append two zeros, sign-extend
// - bits 11-15 and 16-20 index cr source bits of cr logic ops
// - bits 6-8 pick target 4-bit field, field i is bits i*4..i*4+3
// - bits 11-13 pick source 4-bit field, same mapping
// - conditional branches test cr bit indexed by bits 11-15
// - options 00: decrement count, branch if condition false and count test
// - options 01: decrement count, branch if condition true and count test
// - options 0x1: count untouched, branch on condition false or true
// - options 1: ignore condition; 1x00x nonzero, 1x01x zero low word, 1x1xx always
// - target-bit field selects one result bit of cr or fp status
// - bits 16-31 are 16-bit signed, sign-extended to address width
// - register-register form uses 10-bit xo in bits 21-30
// - bits 0-5 always primary opcode; low two fetch address bits ignored
// - bits 6-29 are 24-bit signed, append two zeros, sign-extend
// - link bit set writes following instruction address into link register
package bfd_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSN = 8'h04;
  localparam logic [7:0] OFS_PC_LO = 8'h08;
  localparam logic [7:0] OFS_PC_HI = 8'h0C;
  localparam logic [7:0] OFS_CTR_LO = 8'h10;
  localparam logic [7:0] OFS_CTR_HI = 8'h14;
  localparam logic [7:0] OFS_LR_LO = 8'h18;
  localparam logic [7:0] OFS_LR_HI = 8'h1C;
  localparam logic [7:0] OFS_CR = 8'h20;
  localparam logic [7:0] OFS_TGT_LO = 8'h24;
  localparam logic [7:0] OFS_TGT_HI = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_OPS = 8'h30;
  localparam logic [7:0] OFS_OPC = 8'h34;
  localparam logic [7:0] OFS_SEL = 8'h38;
  localparam logic [7:0] OFS_XO_EXP = 8'h3C;
  localparam logic [7:0] OFS_MASKS = 8'h40;
  localparam logic [7:0] OFS_BITMASK = 8'h44;
  // ctrl field positions
  localparam int CTRL_FORM_LSB = 0;
  localparam int CTRL_MODE64 = 4;
  localparam int CTRL_SPR_SWAP = 5;
  localparam int CTRL_XO_CHECK = 6;
  localparam int CTRL_FXM_VAR = 7;
  localparam logic [31:0] CTRL_RESET = 32'h00000010;
  localparam logic [31:0] CR_RESET = 32'h00000000;
  localparam logic [63:0] REG64_RESET = 64'h0000000000000000;
  // instruction field lsb positions (little-endian index)
  localparam int F_PRIMARY_OPCODE = 26;
  localparam int F_6 = 21;
  localparam int F_11 = 16;
  localparam int F_16 = 11;
  localparam int F_21 = 6;
  localparam int F_26 = 1;
  localparam int F_BIT6 = 25;
  localparam int F_BIT15 = 16;
  localparam int F_BIT20 = 11;
  localparam int F_OE = 10;
  localparam int F_AA = 1;
  localparam int F_LK = 0;
  localparam int F_RC = 0;
  localparam logic [63:0] INSN_BYTES = 64'h0000000000000004;
  typedef enum logic [3:0] {
    FORM_I = 4'h0, FORM_B = 4'h1, FORM_SC = 4'h2, FORM_X = 4'h3,
    FORM_XL = 4'h4, FORM_XFX = 4'h5, FORM_XFL = 4'h6, FORM_XO = 4'h7,
    FORM_A = 4'h8, FORM_M = 4'h9
  } bfd_form_type;
endpackage : bfd_pkg

// *** sim/bfd_decoder_assertions.sv ***
// Purpose: port checker for bfd_decoder
// Assumes: one clock, async active-low reset
// Notes: bound to every bfd_decoder instance
`timescale 1ns/1ps
module bfd_decoder_assertions
  import bfd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic DECODE_VALID,
  input wire logic BRANCH_TAKEN,
  input wire logic [63:0] BRANCH_TARGET,
  input wire logic INVALID_FORM,
  input wire logic LINK_WRITE
);
  // ----
  // checks
  // ----
  wire logic acc = PSEL && PENABLE && PREADY;
  wire logic insn_wr = acc && PWRITE && PADDR == OFS_INSN;
  wire logic lk_in = PWDATA[0];
  wire logic bad = PADDR > OFS_BITMASK || PADDR[1:0] != 2'h0;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  decode_follows_a: assert property (insn_wr |-> ##2 DECODE_VALID)
    else $error("decode missing after write");
  decode_cause_a: assert property (DECODE_VALID |-> $past(insn_wr, 2))
    else $error("decode without write");
  taken_valid_a: assert property (BRANCH_TAKEN |-> DECODE_VALID && !INVALID_FORM)
    else $error("stray taken pulse");
  link_cause_a: assert property (LINK_WRITE |-> !INVALID_FORM && $past(lk_in, 2))
    else $error("link write without link bit");
  target_hold_a: assert property (!DECODE_VALID |-> $stable(BRANCH_TARGET))
    else $error("target moved between decodes");
  invalid_hold_a: assert property (!DECODE_VALID |-> $stable(INVALID_FORM))
    else $error("invalid flag moved");
  target_align_a: assert property (BRANCH_TAKEN |-> BRANCH_TARGET[1:0] == 2'h0)
    else $error("target not word aligned");
  err_decode_a: assert property (acc |-> PSLVERR == bad)
    else $error("slave error mismatch");
endmodule : bfd_decoder_assertions

bind bfd_decoder bfd_decoder_assertions u_bfd_decoder_assertions (.CLOCK(CLOCK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DECODE_VALID(DECODE_VALID),
  .BRANCH_TAKEN(BRANCH_TAKEN), .BRANCH_TARGET(BRANCH_TARGET),
  .INVALID_FORM(INVALID_FORM), .LINK_WRITE(LINK_WRITE));

// *** sim/bfd_fetch_model.sv ***
// Purpose: fetch-side apb master feeding instruction words
// Assumes: slave may hold pready low
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module bfd_fetch_model
  import bfd_pkg::*;
(
  input wire logic CLOCK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [ADDR_W-1:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // idle cycles beyond the first one before a request, so a slow fetch side is seen too
  int gap = 0;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    repeat (gap + 1) @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask : xfer
endmodule : bfd_fetch_model

// *** sim/tb_branch_field_decoder.sv ***
// Purpose: self-checking bench for bfd_decoder
// Assumes: apb master model drives the register bus
// Notes: random fields from seed 48 with forced corner values
`timescale 1ns/1ps
module tb_branch_field_decoder;
  import bfd_pkg::*;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic DECODE_VALID, BRANCH_TAKEN, INVALID_FORM, LINK_WRITE, err, mode64;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, insn, cr;
  logic [63:0] BRANCH_TARGET, pc, ctr;
  logic [2:0] cx = 3'h0;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  bfd_decoder u_bfd_decoder (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DECODE_VALID(DECODE_VALID), .BRANCH_TAKEN(BRANCH_TAKEN),
    .BRANCH_TARGET(BRANCH_TARGET), .INVALID_FORM(INVALID_FORM), .LINK_WRITE(LINK_WRITE));
  bfd_fetch_model u_bfd_fetch_model (.CLOCK(CLOCK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_bfd_fetch_model.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rda(input logic [7:0] a);
    u_bfd_fetch_model.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rda
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rda(a);
    chk(n, {32'h0, e}, {32'h0, rd});
  endtask : rdchk
  function automatic logic [63:0] sx(input logic [63:0] v, input int w);
    logic [63:0] m;
    m = 64'hFFFFFFFFFFFFFFFF << w;
    return v[w-1] ? (v | m) : (v & ~m);
  endfunction : sx
  function automatic logic [63:0] fit(input logic [63:0] v);
    return mode64 ? v : {32'h0, v[31:0]};
  endfunction : fit
  function automatic logic [31:0] fm(input logic [2:0] j);
    return 32'hF0000000 >> (4 * j);
  endfunction : fm
  task automatic setpc();
    pc = {$urandom, $urandom};
    wr(OFS_PC_LO, pc[31:0]);
    wr(OFS_PC_HI, pc[63:32]);
  endtask : setpc
  task automatic decode(input logic [3:0] f);
    wr(OFS_CTRL, {24'h0, cx, mode64, f});
    wr(OFS_INSN, insn);
    // results register one edge after the write edge
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("valid", 64'h1, {63'h0, DECODE_VALID});
  endtask : decode
  task automatic br_chk(input logic [63:0] disp, input logic tk);
    logic [63:0] p;
    p = {pc[63:2], 2'h0};
    chk("taken", {63'h0, tk}, {63'h0, BRANCH_TAKEN});
    chk("target", fit(insn[1] ? disp : p + disp), BRANCH_TARGET);
    chk("link", {63'h0, insn[0]}, {63'h0, LINK_WRITE});
    p = fit(p + 64'h4);
    if (insn[0]) rdchk("lr", OFS_LR_LO, p[31:0]);
  endtask : br_chk
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // ----
  // scenarios
  // ----
  initial begin
    logic [63:0] c2;
    logic [4:0] bo;
    logic [9:0] spr;
    logic z, tk;
    void'($urandom(48));
    mode64 = 1'b1;
    repeat (10) @(posedge CLOCK);
    RSTN <= 1'b1;
    rdchk("ctrl", OFS_CTRL, CTRL_RESET);
    rdchk("cr", OFS_CR, CR_RESET);
    rdchk("unmapped", 8'h48, 32'h0);
    chk("unmapped_err", 64'h1, {63'h0, err});
    wr(8'h06, 32'hFFFFFFFF);
    chk("misaligned_err", 64'h1, {63'h0, err});
    rdchk("ctrl_kept", OFS_CTRL, CTRL_RESET);
    for (int i = 0; i < 40; i++) begin
      mode64 = i[0];
      u_bfd_fetch_model.gap = $urandom_range(2);
      setpc();
      insn = $urandom;
      insn[31:26] = 6'h12;
      if (i < 2) insn[25:2] = i[0] ? 24'h800000 : 24'h7FFFFF;
      decode(FORM_I);
      br_chk(sx({38'h0, insn[25:2], 2'h0}, 26), 1'b1);
    end
    for (int i = 0; i < 64; i++) begin
      mode64 = i[5];
      bo = i[4:0];
      setpc();
      cr = $urandom;
      ctr = {31'h0, 1'($urandom), 30'h0, 2'($urandom_range(2))};
      wr(OFS_CR, cr);
      wr(OFS_CTR_LO, ctr[31:0]);
      wr(OFS_CTR_HI, ctr[63:32]);
      insn = $urandom;
      insn[31:21] = {6'h10, bo};
      c2 = bo[2] ? ctr : ctr - 64'h1;
      z = (!mode64 || (bo[4] && bo[1])) ? c2[31:0] == 32'h0 : c2 == 64'h0;
      tk = (bo[4] || cr[31 - insn[20:16]] == bo[3]) && (bo[2] || z == bo[1]);
      decode(FORM_B);
      br_chk(sx({48'h0, insn[15:2], 2'h0}, 16), tk);
      rdchk("ctr", OFS_CTR_LO, c2[31:0]);
    end
    mode64 = 1'b1;
    for (int i = 0; i < 24; i++) begin
      insn = $urandom;
      cr = $urandom;
      wr(OFS_CR, cr);
      decode(FORM_X);
      chk("imm", sx({48'h0, insn[15:0]}, 16), BRANCH_TARGET);
      chk("flags_x", 64'h0, {62'h0, INVALID_FORM, BRANCH_TAKEN});
      rda(OFS_OPC);
      chk("opc", {48'h0, insn[31:26], insn[10:1]}, {48'h0, rd[31:16]});
      rdchk("masks", OFS_MASKS, fm(insn[25:23]) | fm(insn[20:18]));
      rdchk("bitmask", OFS_BITMASK, 32'h80000000 >> insn[25:21]);
      rda(OFS_STATUS);
      chk("crbits", {62'h0, cr[31 - insn[15:11]], cr[31 - insn[20:16]]}, {62'h0, rd[3:2]});
      chk("srcfield", {60'h0, 4'(cr >> (28 - 4 * insn[20:18]))}, {60'h0, rd[7:4]});
      decode(FORM_XO);
      rda(OFS_OPC);
      chk("opc_xo", {53'h0, insn[9:1], insn[10], insn[0]}, {53'h0, rd[24:14]});
      insn[25] = i[0];
      insn[16] = i[1];
      decode(FORM_XFL);
      chk("invalid", {63'h0, i[0] | i[1]}, {63'h0, INVALID_FORM});
      cx = {i[3], 1'b0, i[2]};
      decode(FORM_XFX);
      chk("invalid_xfx", {63'h0, i[3] & (insn[20] | insn[11])}, {63'h0, INVALID_FORM});
      rda(OFS_OPS);
      spr = i[2] ? {insn[15:11], insn[20:16]} : insn[20:11];
      c2 = {32'h0, insn[25:21], spr, insn[19:12], 8'h0, insn[0]};
      chk("ops_xfx", c2, {32'h0, rd});
      cx = 3'h2;
      wr(OFS_XO_EXP, {22'h0, insn[10:1] ^ {9'h0, i[4]}});
      decode(FORM_X);
      chk("xo_check", {63'h0, i[4]}, {63'h0, INVALID_FORM});
      cx = 3'h0;
      decode(FORM_A);
      rda(OFS_OPC);
      chk("opc_a", {59'h0, insn[5:1]}, {59'h0, rd[20:16]});
      rdchk("ops_a", OFS_OPS, {insn[25:1], 6'h0, insn[0]});
      if (i[0]) insn[25:2] = 24'h0;
      decode(FORM_SC);
      chk("invalid_sc", {63'h0, |insn[25:2]}, {63'h0, INVALID_FORM});
      chk("link_sc", {63'h0, insn[0] & !(|insn[25:2])}, {63'h0, LINK_WRITE});
    end
    finish_test();
  end
endmodule : tb_branch_field_decoder
